// ===== timer_unit.sv
/*
  Timer unit core: clock gate, prescaler with four operation clocks,
  channels 0 and 3 with mode registers, data registers, master/slave
  output mode and channel 3 output polarity.
  Assumes synchronous inputs, one clock, synchronous active-low reset.
*/
`timescale 1ns/1ps

module timer_unit
  import timer_unit_pkg::*;
#(
  parameter int CH = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [15:0] rdata,
  input wire logic [CH-1:0] timerInputPin,
  output logic [CH-1:0] timerOut,
  output logic [CH-1:0] channelTimerInterrupt
);

  typedef struct packed {
    logic [7:0] periphEn;
    logic [15:0] prescale;
    logic [CH-1:0][15:0] mode;
    logic [CH-1:0][15:0] data;
    logic [15:0] outMode;
    logic [15:0] outLevel;
    logic [14:0] div;
    logic [CH-1:0][15:0] capt;
    chan_state_t [CH-1:0] ch;
    logic [15:0] rdata;
    logic [CH-1:0] irq;
  } state_t;

  state_t s_q;
  state_t s_d;
  reg_req_t req;
  logic [3:0] opTick;
  logic [CH-1:0] cntTick;
  logic [CH-1:0] edgeOne;
  logic [CH-1:0] edgeAny;
  logic [CH-1:0] hwTrig;
  logic [CH-1:0] swStart;
  logic unitOn;
  logic [14:0] divNext;

  assign req = '{addr: addr, wdata: wdata, wr: wrStb, rd: rdStb};
  assign unitOn = s_q.periphEn[GATE_BIT];
  assign divNext = s_q.div + 15'h0001;

  // Prescaler taps; B, C, D use their own 4-bit fields
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      logic [3:0] n;
      n = s_q.prescale[k*4 +: PRS_W];
      opTick[k] = unitOn && ((n == 4'h0) ||
        (s_q.div & ((15'h0001 << n) - 15'h0001)) ==
        ((15'h0001 << n) - 15'h0001));
    end
  end

  // Per-channel tick and trigger decode
  generate
    for (genvar c = 0; c < CH; c++) begin : g_ch
      logic [1:0] cks;
      logic [2:0] sts;
      logic opT;
      assign cks = s_q.mode[c][CKS_LSB +: 2];
      assign sts = s_q.mode[c][STS_LSB +: 3];
      // 00 A, 01 C, 10 B, 11 D
      assign opT = (cks == 2'b00) ? opTick[0] :
                   (cks == 2'b01) ? opTick[2] :
                   (cks == 2'b10) ? opTick[1] : opTick[3];
      assign edgeOne[c] = unitOn && timerInputPin[c] && !s_q.ch[c].pinDly;
      assign edgeAny[c] = unitOn && (timerInputPin[c] != s_q.ch[c].pinDly);
      assign cntTick[c] = s_q.mode[c][CCS_BIT] ? edgeOne[c] : opT;
      // Master interrupt from slot 0 starts a slave in slot 1
      assign hwTrig[c] = unitOn && (
        (sts == TRIG_EDGE && edgeOne[c]) ||
        (sts == TRIG_BOTH && edgeAny[c]) ||
        (sts == TRIG_MASTER && c != 0 && s_q.irq[0]));
      assign swStart[c] = req.wr && req.addr == IDX_START &&
                          req.wdata[c == 0 ? 0 : CH3_BIT];
    end
  endgenerate

  // Next-state: registers, prescaler, channel counters
  always_comb begin
    logic [2:0] md;
    logic md0;
    logic up;
    logic trig;
    logic split;
    logic zero;
    s_d = s_q;
    md = '0;
    md0 = 1'b0;
    up = 1'b0;
    trig = 1'b0;
    split = 1'b0;
    zero = 1'b0;
    s_d.irq = '0;
    s_d.div = unitOn ? divNext : 15'h0000;
    if (req.wr) begin
      unique case (req.addr)
        IDX_PERIPH_EN: s_d.periphEn = req.wdata[7:0];
        IDX_PRESCALE: s_d.prescale = req.wdata;
        IDX_MODE0: s_d.mode[0] = req.wdata;
        IDX_MODE3: s_d.mode[1] = req.wdata;
        IDX_DATA0: s_d.data[0] = req.wdata;
        IDX_DATA3: s_d.data[1] = req.wdata;
        IDX_OUT_MODE: s_d.outMode = req.wdata & 16'h0008;
        IDX_OUT_LEVEL: s_d.outLevel = req.wdata & 16'h0008;
        default: ;
      endcase
    end
    for (int c = 0; c < CH; c++) begin
      md = s_q.mode[c][MD_LSB +: 3];
      md0 = s_q.mode[c][MD0_BIT];
      up = (md == MODE_CAPTURE) || (md == MODE_CAP_ONE);
      split = (c != 0) && s_q.mode[c][SPLIT_BIT];
      zero = split ? (s_q.ch[c].cnt[7:0] == 8'h00) :
             (s_q.ch[c].cnt == 16'h0000);
      s_d.ch[c].pinDly = timerInputPin[c];
      trig = hwTrig[c] || swStart[c];
      if (!unitOn) begin
        s_d.ch[c].run = 1'b0;
      end else if (trig && (!s_q.ch[c].run ||
          (md == MODE_ONECOUNT && md0) ||
          md == MODE_INTERVAL || md == MODE_EVENT)) begin
        // Start, or accepted restart
        s_d.ch[c].run = 1'b1;
        s_d.ch[c].cnt = up ? 16'h0000 : s_q.data[c];
        if (up && s_q.ch[c].run) begin
          s_d.capt[c] = s_q.ch[c].cnt;
        end
        if (md0 && (md == MODE_INTERVAL || md == MODE_CAPTURE ||
            (md == MODE_ONECOUNT && s_q.ch[c].run))) begin
          s_d.irq[c] = 1'b1;
        end
      end else if (s_q.ch[c].run && cntTick[c]) begin
        if (up) begin
          s_d.ch[c].cnt = s_q.ch[c].cnt + 16'h0001;
        end else if (zero) begin
          s_d.irq[c] = 1'b1;
          if (md == MODE_ONECOUNT || md == MODE_CAP_ONE) begin
            s_d.ch[c].run = 1'b0;
          end else begin
            s_d.ch[c].cnt = s_q.data[c];
          end
        end else begin
          s_d.ch[c].cnt = s_q.ch[c].cnt - 16'h0001;
        end
      end
      // Output: slave mode sets on master irq, resets on own
      if (c != 0 && s_q.outMode[CH3_BIT]) begin
        if (s_d.irq[c]) begin
          s_d.ch[c].tout = 1'b0;
        end else if (s_d.irq[0]) begin
          s_d.ch[c].tout = 1'b1;
        end
      end else if (s_d.irq[c] && md != MODE_EVENT) begin
        s_d.ch[c].tout = !s_q.ch[c].tout;
      end
    end
    s_d.rdata = 16'h0000;
    if (req.rd) begin
      unique case (req.addr)
        IDX_PERIPH_EN: s_d.rdata = {8'h00, s_q.periphEn};
        IDX_PRESCALE: s_d.rdata = s_q.prescale;
        IDX_MODE0: s_d.rdata = s_q.mode[0];
        IDX_MODE3: s_d.rdata = s_q.mode[1];
        IDX_DATA0: s_d.rdata = s_q.data[0];
        IDX_DATA3: s_d.rdata = s_q.data[1];
        IDX_OUT_MODE: s_d.rdata = s_q.outMode;
        IDX_OUT_LEVEL: s_d.rdata = s_q.outLevel;
        IDX_STATUS: s_d.rdata = {12'h000, s_q.ch[1].run, 2'b00, s_q.ch[0].run};
        IDX_COUNT0: s_d.rdata = s_q.ch[0].cnt;
        IDX_COUNT3: s_d.rdata = s_q.ch[1].cnt;
        default: s_d.rdata = 16'h0000;
      endcase
    end
  end

  // Single state register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.data <= {CH{RST_DATA}};
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign channelTimerInterrupt = s_q.irq;
  // Polarity applied at the pin
  assign timerOut[0] = s_q.ch[0].tout ^ s_q.outLevel[0];
  assign timerOut[1] = s_q.ch[1].tout ^ s_q.outLevel[CH3_BIT];

  // Gate off means no count and no interrupt
  AST_GATE_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
    !unitOn |=> channelTimerInterrupt == '0)
    else $error("interrupt while unit clock gated");

  AST_GATE_STOP: assert property (@(posedge clk) disable iff (!rst_b)
    !unitOn |=> !s_q.ch[0].run && !s_q.ch[1].run)
    else $error("channel runs with gate off");

  AST_DIV_ONE: assert property (@(posedge clk) disable iff (!rst_b)
    unitOn && s_q.prescale[3:0] == 4'h0 |-> opTick[0])
    else $error("undivided clock A missing tick");

  AST_DIV_TWO: assert property (@(posedge clk) disable iff (!rst_b)
    opTick[0] && s_q.prescale[3:0] == 4'h1 &&
    !(req.wr && req.addr == IDX_PRESCALE) |=> !opTick[0])
    else $error("divide by two ticked twice");

  AST_CLK_SEL: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.mode[0][CCS_BIT] == 1'b0 && s_q.mode[0][15:14] == 2'b01
    |-> cntTick[0] == opTick[2])
    else $error("clock select mismatch");

  AST_PIN_COUNT: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.mode[0][CCS_BIT] |-> cntTick[0] == edgeOne[0])
    else $error("pin count source mismatch");

  sequence downStep(int c);
    s_q.ch[c].run && cntTick[c] && !hwTrig[c] && !swStart[c] &&
    s_q.ch[c].cnt != 16'h0000 && s_q.mode[c][3:1] == 3'h0 &&
    (c == 0 || !s_q.mode[c][SPLIT_BIT]);
  endsequence

  AST_DOWN_COUNT: assert property (@(posedge clk) disable iff (!rst_b)
    downStep(0) |=> s_q.ch[0].cnt == $past(s_q.ch[0].cnt) - 16'h0001)
    else $error("interval mode failed to count down");

  sequence upStep(int c);
    s_q.ch[c].run && cntTick[c] && !hwTrig[c] && !swStart[c] &&
    s_q.mode[c][3:1] == 3'h2;
  endsequence

  AST_UP_COUNT: assert property (@(posedge clk) disable iff (!rst_b)
    upStep(0) |=> s_q.ch[0].cnt == $past(s_q.ch[0].cnt) + 16'h0001)
    else $error("capture mode failed to count up");

  AST_RELOAD: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.ch[0].run && cntTick[0] && !hwTrig[0] && !swStart[0] &&
    s_q.ch[0].cnt == 16'h0000 && s_q.mode[0][3:1] == 3'h0 &&
    !req.wr |=> channelTimerInterrupt[0] &&
    s_q.ch[0].cnt == s_q.data[0])
    else $error("interval reload or interrupt missing");

  AST_ONE_IGNORE: assert property (@(posedge clk) disable iff (!rst_b)
    unitOn && s_q.ch[1].run && s_q.mode[1][3:0] == 4'h8 && swStart[1] &&
    s_q.ch[1].cnt[7:0] != 8'h00 |=> !channelTimerInterrupt[1])
    else $error("one-count restart not ignored");

  AST_SLAVE_SET: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.outMode[CH3_BIT] && s_d.irq[0] && !s_d.irq[1]
    |=> s_q.ch[1].tout)
    else $error("slave output not set by master");

  AST_POLARITY: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.outLevel[CH3_BIT] |-> timerOut[1] == !s_q.ch[1].tout)
    else $error("output polarity wrong");

  // Trigger and split checks; prohibited codes are not flagged
  AST_BOTH_EDGE: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.mode[0][10:8] == 3'h2 && edgeAny[0] |-> hwTrig[0])
    else $error("both-edge trigger missed");

  AST_ONE_RESTART: assert property (@(posedge clk) disable iff (!rst_b)
    unitOn && s_q.ch[1].run && s_q.mode[1][3:0] == 4'h9 && swStart[1]
    |=> channelTimerInterrupt[1] &&
    s_q.ch[1].cnt == $past(s_q.data[1]))
    else $error("one-count restart not taken");

  AST_CAP_ONE_QUIET: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.mode[1][3:0] == 4'hC && (swStart[1] || hwTrig[1])
    |=> !channelTimerInterrupt[1])
    else $error("capture one-count raised an interrupt");

  AST_SPLIT_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.ch[1].run && cntTick[1] && !hwTrig[1] && !swStart[1] &&
    s_q.mode[1][SPLIT_BIT] && s_q.mode[1][3:1] == 3'h0 &&
    s_q.ch[1].cnt[7:0] == 8'h00 |=> channelTimerInterrupt[1])
    else $error("eight-bit count missed its zero");

endmodule

// ===== timer_unit_pkg.sv
/*
  Package for the two-channel timer unit: register indices, field
  positions, reset values and mode encodings.
  Assumes a plain address/strobe register port and one 125 MHz clock.
*/
package timer_unit_pkg;

  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] IDX_PERIPH_EN = 4'h0;
  localparam logic [ADDR_W-1:0] IDX_PRESCALE = 4'h1;
  localparam logic [ADDR_W-1:0] IDX_MODE0 = 4'h2;
  localparam logic [ADDR_W-1:0] IDX_MODE3 = 4'h3;
  localparam logic [ADDR_W-1:0] IDX_DATA0 = 4'h4;
  localparam logic [ADDR_W-1:0] IDX_DATA3 = 4'h5;
  localparam logic [ADDR_W-1:0] IDX_OUT_MODE = 4'h6;
  localparam logic [ADDR_W-1:0] IDX_OUT_LEVEL = 4'h7;
  localparam logic [ADDR_W-1:0] IDX_START = 4'h8;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 4'h9;
  localparam logic [ADDR_W-1:0] IDX_COUNT0 = 4'hA;
  localparam logic [ADDR_W-1:0] IDX_COUNT3 = 4'hB;

  localparam int GATE_BIT = 0;
  localparam int PRS_LSB = 0;
  localparam int PRS_W = 4;
  localparam int CKS_LSB = 14;
  localparam int CCS_BIT = 12;
  localparam int SPLIT_BIT = 11;
  localparam int STS_LSB = 8;
  localparam int MD_LSB = 1;
  localparam int MD0_BIT = 0;
  localparam int CH3_BIT = 3;

  localparam logic [15:0] RST_REG = 16'h0000;
  localparam logic [15:0] RST_DATA = 16'hFFFF;

  typedef enum logic [2:0] {
    MODE_INTERVAL = 3'h0,
    MODE_CAPTURE = 3'h2,
    MODE_EVENT = 3'h3,
    MODE_ONECOUNT = 3'h4,
    MODE_CAP_ONE = 3'h6
  } op_mode_t;

  typedef enum logic [2:0] {
    TRIG_SOFT = 3'h0,
    TRIG_EDGE = 3'h1,
    TRIG_BOTH = 3'h2,
    TRIG_MASTER = 3'h4
  } trig_sel_t;

  // Register port request bundle
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // One channel's run state
  typedef struct packed {
    logic [15:0] cnt;
    logic run;
    logic tout;
    logic pinDly;
  } chan_state_t;

endpackage

// ===== tb.sv
/*
  Self-checking bench for timer_unit: register port, clock selection,
  count direction, start behaviour, trigger and output modes.
  Assumes the strobe port with read data one cycle after the strobe.
*/
`timescale 1ns/1ps
module tb;
  import timer_unit_pkg::*;
  logic clk, rst_b, wrStb, rdStb;
  logic [ADDR_W-1:0] addr;
  logic [15:0] wdata, rdata, v, w;
  logic [1:0] timerInputPin, timerOut, channelTimerInterrupt;
  logic [15:0] preT [6] = '{16'h3210, 16'h3210, 16'h3210, 16'h3210,
    16'h0005, 16'h0001};
  int cksT [6] = '{0, 1, 2, 3, 0, 0};
  int expT [6] = '{2, 8, 4, 16, 64, 4};
  logic [15:0] slowT [2] = '{16'h0008, 16'h000C};
  int failCount, nChecks, n;

  timer_unit u_dut (
    .clk(clk),
    .rst_b(rst_b),
    .addr(addr),
    .wdata(wdata),
    .wrStb(wrStb),
    .rdStb(rdStb),
    .rdata(rdata),
    .timerInputPin(timerInputPin),
    .timerOut(timerOut),
    .channelTimerInterrupt(channelTimerInterrupt)
  );

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic completeRun();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nChecks++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Strobe drops a cycle later, so calls never collide on one edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk(d, e);
  endtask

  task automatic rst();
    rst_b <= 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
  endtask

  // Bounded wait for a pulse; edges waited land in n
  task automatic waitIrq(input int ch, input int lim);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (channelTimerInterrupt[ch] !== 1'b1 && n < lim);
    if (channelTimerInterrupt[ch] !== 1'b1) begin
      failCount++;
      $display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      completeRun();
    end
  endtask

  // Window in which no pulse may appear
  task automatic quiet(input int ch, input int len);
    n = 0;
    repeat (len) begin
      @(posedge clk);
      if (channelTimerInterrupt[ch] !== 1'b0) n++;
    end
    chk(16'(n), 16'h0000);
  endtask

  task automatic run0(input logic [15:0] m, d, p);
    wr(IDX_PERIPH_EN, 16'h0001);
    wr(IDX_PRESCALE, p);
    wr(IDX_MODE0, m);
    wr(IDX_DATA0, d);
    wr(IDX_START, 16'h0001);
  endtask

  initial begin
    rst_b = 1'b0;
    addr = '0;
    wdata = 16'h0000;
    wrStb = 1'b0;
    rdStb = 1'b0;
    timerInputPin = 2'b00;
    failCount = 0;
    nChecks = 0;
    rst();
    // Reset values, masks and an unmapped index
    rchk(IDX_PERIPH_EN, RST_REG);
    rchk(IDX_PRESCALE, RST_REG);
    rchk(IDX_MODE3, RST_REG);
    rchk(IDX_DATA0, RST_DATA);
    wr(4'hC, 16'h1234);
    rchk(4'hC, 16'h0000);
    wr(IDX_OUT_MODE, 16'hFFFF);
    rchk(IDX_OUT_MODE, 16'h0008);
    wr(IDX_OUT_LEVEL, 16'hFFFF);
    rchk(IDX_OUT_LEVEL, 16'h0008);
    chk({14'h0000, timerOut}, 16'h0002);
    // Start ignored while the unit clock is gated
    rst();
    wr(IDX_MODE0, 16'h0001);
    wr(IDX_DATA0, 16'h0002);
    wr(IDX_START, 16'h0001);
    quiet(0, 20);
    wr(IDX_PERIPH_EN, 16'h0001);
    wr(IDX_START, 16'h0001);
    waitIrq(0, 4);
    waitIrq(0, 10);
    chk(16'(n), 16'h0003);
    // Bit 0 clear: silent start, period still data plus one
    rst();
    run0(16'h0000, 16'h0004, 16'h0000);
    quiet(0, 3);
    waitIrq(0, 10);
    waitIrq(0, 10);
    chk(16'(n), 16'h0005);
    // Operation clock taps and select codes
    for (int i = 0; i < 6; i++) begin
      rst();
      run0(16'(cksT[i]) << 14, 16'h0001, preT[i]);
      waitIrq(0, 400);
      waitIrq(0, 400);
      chk(16'(n), 16'(expT[i]));
    end
    // Count direction, capture up and interval down
    rst();
    run0(16'h0004, 16'h0000, 16'h0000);
    rd(IDX_COUNT0, v);
    rd(IDX_COUNT0, w);
    chk(16'(w > v), 16'h0001);
    rst();
    run0(16'h0000, 16'h0100, 16'h0000);
    rd(IDX_COUNT0, v);
    rd(IDX_COUNT0, w);
    chk(16'(w < v), 16'h0001);
    // Pin as count source: frozen without edges
    rst();
    run0(16'h1006, 16'h0100, 16'h0000);
    rd(IDX_COUNT0, v);
    repeat (10) @(posedge clk);
    rd(IDX_COUNT0, w);
    chk(w, v);
    timerInputPin <= 2'b01;
    repeat (3) @(posedge clk);
    timerInputPin <= 2'b00;
    repeat (3) @(posedge clk);
    rd(IDX_COUNT0, w);
    chk(16'(w != v), 16'h0001);
    // Pin triggers: both edges, then rising edge only
    rst();
    wr(IDX_PERIPH_EN, 16'h0001);
    wr(IDX_MODE0, 16'h0201);
    wr(IDX_DATA0, 16'h0100);
    timerInputPin <= 2'b01;
    waitIrq(0, 4);
    timerInputPin <= 2'b00;
    waitIrq(0, 4);
    wr(IDX_MODE0, 16'h0101);
    timerInputPin <= 2'b01;
    waitIrq(0, 4);
    timerInputPin <= 2'b00;
    quiet(0, 4);
    // Restart while counting in one-count modes
    rst();
    wr(IDX_PERIPH_EN, 16'h0001);
    wr(IDX_MODE3, 16'h0009);
    wr(IDX_DATA3, 16'h0100);
    wr(IDX_START, 16'h0008);
    repeat (4) @(posedge clk);
    wr(IDX_START, 16'h0008);
    waitIrq(1, 4);
    for (int i = 0; i < 2; i++) begin
      rst();
      wr(IDX_PERIPH_EN, 16'h0001);
      wr(IDX_MODE3, slowT[i]);
      wr(IDX_DATA3, 16'h0100);
      wr(IDX_START, 16'h0008);
      quiet(1, 6);
      rd(IDX_COUNT3, v);
      wr(IDX_START, 16'h0008);
      rd(IDX_COUNT3, w);
      chk(16'(i == 0 ? w < v : w > v), 16'h0001);
      quiet(1, 6);
    end
    // Eight-bit split: only the low byte counts to zero
    rst();
    wr(IDX_PERIPH_EN, 16'h0001);
    wr(IDX_MODE3, 16'h0800);
    wr(IDX_DATA3, 16'h0102);
    wr(IDX_START, 16'h0008);
    waitIrq(1, 10);
    waitIrq(1, 10);
    chk(16'(n), 16'h0003);
    // Slave one-count started by master, slave output mode
    rst();
    wr(IDX_OUT_MODE, 16'h0008);
    wr(IDX_MODE3, 16'h0408);
    wr(IDX_DATA3, 16'h0010);
    run0(16'h0000, 16'h0080, 16'h0000);
    waitIrq(0, 200);
    repeat (3) @(posedge clk);
    chk(16'(timerOut[1]), 16'h0001);
    rd(IDX_STATUS, v);
    chk(v & 16'h0008, 16'h0008);
    waitIrq(1, 40);
    repeat (3) @(posedge clk);
    chk(16'(timerOut[1]), 16'h0000);
    completeRun();
  end
endmodule
